// ---- design/asram_host.sv ----
// host controller driving an asynchronous 16-bit static memory by its pins
// ----------------------------------------------------------------
// Contract
// R1: two byte lanes, each with own enable
// R2: lower read: selects, drive low, lower lane
// R3: upper read: selects, drive low, upper lane
// R4: full read: both lanes enabled, strobe high
// R5: drive enable high floats device lanes
// R6: lower write: strobe low, lower lane only
// R7: upper write: strobe low, upper lane only
// R8: full write: strobe low, both lanes
// R9: host times write by one pulsed control
// R10: capture only while all write controls asserted
// R11: any deselect condition floats device lanes
// R12: never drive lanes the device drives
// R13: deselect means standby, retention only
// R14: standby ignores every other input
// R15: retention: no access until recovery done
// R16: strobe low overrides drive enable, no output
// R17: strobe stays high during read
// R18: unselected lane keeps its contents
// R19: 17-bit address held through access
// ----------------------------------------------------------------
`timescale 1ns/1ps
module asram_host
  import asram_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic [1:0] req_lanes,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [DATA_W-1:0] req_wdata,
  output logic resp_valid,
  output logic [DATA_W-1:0] resp_rdata,
  input wire logic retain_req,
  output logic retain_active,
  output logic select_active_low,
  output logic select_active_high,
  output logic output_drive_enable_n,
  output logic write_strobe_n,
  output logic lower_lane_enable_n,
  output logic upper_lane_enable_n,
  output logic [ADDR_W-1:0] word_address,
  input wire logic [DATA_W-1:0] data_lanes_i,
  output logic [DATA_W-1:0] data_lanes_o,
  output logic data_lanes_oe
);

  asram_regs_t r;
  asram_regs_t n;

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_comb begin
    n = r;
    n.resp_valid = 1'b0;
    n.sync1 = data_lanes_i;
    n.sync2 = r.sync1;
    case (r.st)
      ST_IDLE: begin
        n.cnt = 4'h0;
        if (retain_req) begin
          n.pins = PINS_IDLE; // R13
          n.st = ST_RETAIN;
        end else if (req_valid) begin
          n.pins.word_address = req_addr; // R19
          n.pins.lower_lane_enable_n = ~req_lanes[0]; // R1 R6
          n.pins.upper_lane_enable_n = ~req_lanes[1]; // R7 R18
          n.pins.select_active_low = 1'b0;
          n.pins.select_active_high = 1'b1;
          if (req_write) begin
            n.pins.data_lanes_o = req_wdata; // R8
            n.pins.data_lanes_oe = 1'b1;
            n.st = ST_WR_SETUP;
          end else begin
            n.pins.output_drive_enable_n = 1'b0; // R2
            n.pins.write_strobe_n = 1'b1; // R17
            n.pins.data_lanes_oe = 1'b0; // R12
            n.st = ST_RD;
          end
        end
      end
      ST_RD: begin
        n.cnt = r.cnt + 4'h1;
        if (r.cnt == 4'(RD_CYC - 1)) begin
          // unselected lane reads as zero
          n.rdata[DATA_W-1:LANE_W] = r.pins.upper_lane_enable_n ?
            8'h00 : r.sync2[DATA_W-1:LANE_W]; // R3
          n.rdata[LANE_W-1:0] = r.pins.lower_lane_enable_n ?
            8'h00 : r.sync2[LANE_W-1:0]; // R4
          n.resp_valid = 1'b1;
          n.pins = PINS_IDLE;
          n.pins.word_address = r.pins.word_address;
          n.cnt = 4'h0;
          n.st = ST_TURN;
        end
      end
      ST_TURN: begin
        // let the device float before anyone drives
        n.cnt = r.cnt + 4'h1;
        if (r.cnt == 4'(HZ_CYC - 1)) begin
          n.st = ST_IDLE; // R5
        end
      end
      ST_WR_SETUP: begin
        n.pins.write_strobe_n = 1'b0; // R9
        n.cnt = 4'h0;
        n.st = ST_WR_PULSE;
      end
      ST_WR_PULSE: begin
        n.cnt = r.cnt + 4'h1;
        if (r.cnt == 4'(WP_CYC - 1)) begin
          n.pins.write_strobe_n = 1'b1; // R10
          n.st = ST_WR_END;
        end
      end
      ST_WR_END: begin
        n.pins = PINS_IDLE;
        n.pins.word_address = r.pins.word_address;
        n.resp_valid = 1'b1;
        n.st = ST_IDLE;
      end
      ST_RETAIN: begin
        n.pins = PINS_IDLE; // R14
        n.cnt = 4'h0;
        if (!retain_req) begin
          n.st = ST_RECOVER;
        end
      end
      ST_RECOVER: begin
        n.cnt = r.cnt + 4'h1;
        if (r.cnt == 4'(REC_CYC - 1)) begin
          n.st = ST_IDLE; // R15
        end
      end
      default: begin
        n = REGS_RESET;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      r <= REGS_RESET;
    end else begin
      r <= n;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign req_ready = (r.st == ST_IDLE) && !retain_req;
  assign resp_valid = r.resp_valid;
  assign resp_rdata = r.rdata;
  assign retain_active = (r.st == ST_RETAIN);
  assign select_active_low = r.pins.select_active_low;
  assign select_active_high = r.pins.select_active_high;
  assign output_drive_enable_n = r.pins.output_drive_enable_n;
  assign write_strobe_n = r.pins.write_strobe_n;
  assign lower_lane_enable_n = r.pins.lower_lane_enable_n;
  assign upper_lane_enable_n = r.pins.upper_lane_enable_n;
  assign word_address = r.pins.word_address;
  assign data_lanes_o = r.pins.data_lanes_o;
  assign data_lanes_oe = r.pins.data_lanes_oe;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence s_we_fall;
    $fell(write_strobe_n);
  endsequence

  sequence s_we_pulse;
    !write_strobe_n [*2] ##1 write_strobe_n;
  endsequence

  sequence s_read_start;
    $fell(output_drive_enable_n);
  endsequence

  sequence s_read_body;
    !output_drive_enable_n [*4] ##1 (output_drive_enable_n && resp_valid);
  endsequence

  property p_we_high_read;
    !output_drive_enable_n |-> write_strobe_n;
  endproperty
  a_we_high_read: assert property (p_we_high_read) // R17
    else $error("write strobe low during read");

  property p_no_drive_read;
    !output_drive_enable_n |-> !data_lanes_oe;
  endproperty
  a_no_drive_read: assert property (p_no_drive_read) // R12
    else $error("host drives lanes while device may drive");

  property p_write_pulse;
    s_we_fall |-> s_we_pulse;
  endproperty
  a_write_pulse: assert property (p_write_pulse) // R9
    else $error("write strobe pulse has wrong width");

  property p_write_data;
    !write_strobe_n |-> data_lanes_oe && output_drive_enable_n &&
      !select_active_low && select_active_high && $stable(data_lanes_o);
  endproperty
  a_write_data: assert property (p_write_data) // R10
    else $error("write conditions not held during strobe");

  property p_addr_hold;
    !select_active_low && $past(!select_active_low) |->
      $stable(word_address);
  endproperty
  a_addr_hold: assert property (p_addr_hold) // R19
    else $error("address moved during access");

  property p_read_cycle;
    s_read_start |-> s_read_body;
  endproperty
  a_read_cycle: assert property (p_read_cycle) // R2
    else $error("read cycle length wrong");

  property p_lane_follow;
    req_valid && req_ready |=>
      lower_lane_enable_n == !$past(req_lanes[0]) &&
      upper_lane_enable_n == !$past(req_lanes[1]);
  endproperty
  a_lane_follow: assert property (p_lane_follow) // R6
    else $error("lane enables do not follow request");

  property p_retain;
    retain_active |-> select_active_low && !select_active_high &&
      !data_lanes_oe && write_strobe_n;
  endproperty
  a_retain: assert property (p_retain) // R13
    else $error("device not deselected in retention");

  property p_recover;
    $fell(retain_active) |-> !req_ready [*2];
  endproperty
  a_recover: assert property (p_recover) // R15
    else $error("access offered before recovery time");

  property p_turn;
    $rose(output_drive_enable_n) |-> !data_lanes_oe ##1 !data_lanes_oe;
  endproperty
  a_turn: assert property (p_turn) // R5
    else $error("lanes driven before device floated");

endmodule

// ---- dv/asram_mem_model.sv ----
// behavioural async 16-bit static memory facing the host controller
`timescale 1ns/1ps
module asram_mem_model
  import asram_pkg::*;
(
  input wire logic sel_n,
  input wire logic sel,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic lo_n,
  input wire logic up_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] host_d,
  input wire logic host_oe,
  output logic [DATA_W-1:0] bus,
  output logic clash
);
  logic [DATA_W-1:0] mem [2**ADDR_W];
  logic [DATA_W-1:0] q;
  logic [DATA_W-1:0] wd;
  logic on;
  logic rd_lo;
  logic rd_up;
  assign on = !sel_n && sel;
  assign rd_lo = on && !oe_n && we_n && !lo_n;
  assign rd_up = on && !oe_n && we_n && !up_n;
  assign q = mem[addr];
  assign wd = host_oe ? host_d : 'x;
  assign clash = host_oe && (rd_lo || rd_up);
  // released lanes float: show inverse of the stored word
  always_comb begin
    bus = host_oe ? host_d : ~q;
    if (rd_lo) bus[7:0] = q[7:0];
    if (rd_up) bus[15:8] = q[15:8];
  end
  always @* begin
    if (on && !we_n && !lo_n) mem[addr][7:0] = wd[7:0];
    if (on && !we_n && !up_n) mem[addr][15:8] = wd[15:8];
  end
endmodule

// ---- dv/tb_asram_host.sv ----
// self-checking bench for the async sram host controller
`timescale 1ns/1ps
module tb_asram_host;
  import asram_pkg::*;
  logic clk = 0;
  logic srst = 1;
  logic req_valid = 0;
  logic req_write = 0;
  logic [1:0] req_lanes = 2'h0;
  logic [ADDR_W-1:0] req_addr = '0;
  logic [DATA_W-1:0] req_wdata = 16'h0000;
  logic retain_req = 0;
  logic req_ready, resp_valid, retain_active;
  logic sel_n, sel, oe_n, we_n, lo_n, up_n, host_oe, clash;
  logic [ADDR_W-1:0] word_address;
  logic [DATA_W-1:0] resp_rdata, bus, host_d, rd;
  int error_cnt = 0;
  int checks_done = 0;
  int cyc = 0;
  always #25 clk = ~clk;
  asram_host dut (.clk(clk), .srst(srst), .req_valid(req_valid),
    .req_ready(req_ready), .req_write(req_write), .req_lanes(req_lanes),
    .req_addr(req_addr), .req_wdata(req_wdata), .resp_valid(resp_valid),
    .resp_rdata(resp_rdata), .retain_req(retain_req),
    .retain_active(retain_active), .select_active_low(sel_n),
    .select_active_high(sel), .output_drive_enable_n(oe_n),
    .write_strobe_n(we_n), .lower_lane_enable_n(lo_n),
    .upper_lane_enable_n(up_n), .word_address(word_address),
    .data_lanes_i(bus), .data_lanes_o(host_d), .data_lanes_oe(host_oe));
  asram_mem_model mem (.sel_n(sel_n), .sel(sel), .oe_n(oe_n),
    .we_n(we_n), .lo_n(lo_n), .up_n(up_n), .addr(word_address),
    .host_d(host_d), .host_oe(host_oe), .bus(bus), .clash(clash));
  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask
  // one user request, held until taken, then wait for its answer
  task automatic xfer(logic wr, logic [1:0] ln, logic [16:0] a,
    logic [15:0] d);
    int n;
    n = 0;
    req_valid = 1;
    req_write = wr;
    req_lanes = ln;
    req_addr = a;
    req_wdata = d;
    while (req_ready !== 1'b1) @(negedge clk);
    @(negedge clk);
    req_valid = 0;
    do begin
      @(negedge clk);
      n++;
    end while (resp_valid !== 1'b1 && n < 20);
    chk("answer", 16'h0001, {15'h0000, resp_valid});
    rd = resp_rdata;
  endtask
  task automatic t_full();
    xfer(1, 2'h3, 17'h1_FFFF, 16'hA55A);
    xfer(1, 2'h3, 17'h0_0000, 16'h0F0F);
    xfer(0, 2'h3, 17'h1_FFFF, 16'h0000);
    chk("top word", 16'hA55A, rd);
    xfer(0, 2'h3, 17'h0_0000, 16'h0000);
    chk("low word", 16'h0F0F, rd);
    $display("test full done");
  endtask
  task automatic t_lane();
    xfer(1, 2'h3, 17'h0_0005, 16'h1234);
    xfer(1, 2'h1, 17'h0_0005, 16'hFFCD);
    xfer(1, 2'h2, 17'h0_0005, 16'hEF00);
    xfer(1, 2'h0, 17'h0_0005, 16'h5555);
    xfer(0, 2'h1, 17'h0_0005, 16'h0000);
    chk("lower", 16'h00CD, rd);
    xfer(0, 2'h2, 17'h0_0005, 16'h0000);
    chk("upper", 16'hEF00, rd);
    xfer(0, 2'h3, 17'h0_0005, 16'h0000);
    chk("word", 16'hEFCD, rd);
    $display("test lane done");
  endtask
  task automatic t_keep();
    retain_req = 1;
    // entry waits for a read turnaround to end first
    repeat (2) @(negedge clk);
    repeat (3) begin
      chk("standby", 16'h0001,
        {15'h0000, retain_active && !req_ready && sel_n && !sel});
      @(negedge clk);
    end
    retain_req = 0;
    @(negedge clk);
    chk("recover", 16'h0000, {15'h0000, req_ready});
    xfer(0, 2'h3, 17'h0_0005, 16'h0000);
    chk("kept", 16'hEFCD, rd);
    $display("test keep done");
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // bus watch and hang limit
  always @(negedge clk) begin
    cyc++;
    if (!srst && (clash || (!oe_n && (!we_n || host_oe)))) begin
      error_cnt++;
      $display("BAD bus drive exp 0 got 1");
    end
    if (cyc == 2000) begin
      error_cnt++;
      end_sim();
    end
  end
  initial begin
    repeat (4) @(negedge clk);
    srst = 0;
    t_full();
    t_lane();
    t_keep();
    end_sim();
  end
endmodule

// ---- include/asram_pkg.sv ----
// package: constants, states and carriers for the async sram host controller
package asram_pkg;

  // ----------------------------------------------------------------
  // widths and clock
  // ----------------------------------------------------------------
  localparam int ADDR_W = 17;
  localparam int DATA_W = 16;
  localparam int LANE_W = 8;
  localparam int CLK_PERIOD_NS = 50;
  localparam int SYNC_STAGES = 2;

  // ----------------------------------------------------------------
  // device timing in ns
  // ----------------------------------------------------------------
  localparam int T_ACC_NS = 85;
  localparam int T_WP_NS = 60;
  localparam int T_HZ_NS = 30;
  localparam int T_REC_NS = 100;

  // least time rounded up to whole cycles, never below one
  function automatic int cyc_min(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int ACC_CYC = cyc_min(T_ACC_NS);
  localparam int WP_CYC = cyc_min(T_WP_NS);
  localparam int HZ_CYC = cyc_min(T_HZ_NS);
  localparam int REC_CYC = cyc_min(T_REC_NS);
  localparam int RD_CYC = ACC_CYC + SYNC_STAGES;

  // ----------------------------------------------------------------
  // states and carriers
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_RD,
    ST_TURN,
    ST_WR_SETUP,
    ST_WR_PULSE,
    ST_WR_END,
    ST_RETAIN,
    ST_RECOVER
  } asram_state_t;

  typedef struct packed {
    logic select_active_low;
    logic select_active_high;
    logic output_drive_enable_n;
    logic write_strobe_n;
    logic lower_lane_enable_n;
    logic upper_lane_enable_n;
    logic [ADDR_W-1:0] word_address;
    logic [DATA_W-1:0] data_lanes_o;
    logic data_lanes_oe;
  } asram_pins_t;

  typedef struct packed {
    asram_state_t st;
    logic [3:0] cnt;
    asram_pins_t pins;
    logic [DATA_W-1:0] sync1;
    logic [DATA_W-1:0] sync2;
    logic [DATA_W-1:0] rdata;
    logic resp_valid;
  } asram_regs_t;

  localparam asram_pins_t PINS_IDLE = '{
    select_active_low: 1'b1,
    select_active_high: 1'b0,
    output_drive_enable_n: 1'b1,
    write_strobe_n: 1'b1,
    lower_lane_enable_n: 1'b1,
    upper_lane_enable_n: 1'b1,
    word_address: 17'h0_0000,
    data_lanes_o: 16'h0000,
    data_lanes_oe: 1'b0
  };

  localparam asram_regs_t REGS_RESET = '{
    st: ST_IDLE,
    cnt: 4'h0,
    pins: PINS_IDLE,
    sync1: 16'h0000,
    sync2: 16'h0000,
    rdata: 16'h0000,
    resp_valid: 1'b0
  };

endpackage
